//--- verilog/sncs_defines.svh
`ifndef SNCS_DEFINES_SVH
`define SNCS_DEFINES_SVH
`define SNCS_ADDR_LSB 0
`define SNCS_ADDR_MSB 5
`define SNCS_RATE_LSB 6
`define SNCS_RATE_MSB 7
`define SNCS_CLK_HZ 40000000
`define SNCS_RATE_9K6 9600
`define SNCS_RATE_38K4 38400
`define SNCS_RATE_115K2 115200
// Last settle count before the latch; settling lasts this value plus one cycles, switches latched 6 cycles after reset release
`define SNCS_SETTLE 4'h4
// Register map of the plain register port
`define SNCS_REG_STATUS 2'h0
`define SNCS_REG_NV 2'h1
`define SNCS_REG_DIV 2'h2
`define SNCS_REG_232 2'h3
`endif

//--- verilog/sncs_pkg.sv
package sncs_pkg;
    typedef enum logic [1:0] {
        SNCS_RATE_NV,
        SNCS_RATE_9K6,
        SNCS_RATE_38K4,
        SNCS_RATE_115K2
    } sncs_rate_t;
    typedef enum logic [1:0] {
        SNCS_SETTLING,
        SNCS_LATCH,
        SNCS_RUN
    } sncs_state_t;
endpackage

//--- verilog/sncs_sync3.sv
`timescale 1ns/1ps
module sncs_sync3
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Bits change only when second and third stage agree
    always_ff @(posedge clock)
    begin
        if (srst)
            dout <= '0;
        else
            dout <= (dout & (s2 ^ s3)) | (s2 & ~(s2 ^ s3));
    end

    chk_sync_follow: assert property
        (@(posedge clock) disable iff (srst)
        ((dout ^ $past(s2)) & ~($past(s2) ^ $past(s3))) == '0)
        else $error("synchroniser missed agreed bits");
    chk_sync_hold: assert property
        (@(posedge clock) disable iff (srst)
        ((dout ^ $past(dout)) & ($past(s2) ^ $past(s3))) == '0)
        else $error("synchroniser took disputed bits");
endmodule // sncs_sync3

//--- verilog/sncs_config_select.sv
`timescale 1ns/1ps
`include "sncs_defines.svh"
module sncs_config_select
#(
    parameter int CLK_HZ = `SNCS_CLK_HZ
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] switch_on,
    input wire logic [1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [5:0] node_addr,
    output logic [1:0] rate_code,
    output logic [15:0] rate_div,
    output logic cfg_valid,
    output logic [15:0] rs232_div
);
    localparam logic [15:0] DIV_9K6 = 16'(CLK_HZ / `SNCS_RATE_9K6);
    localparam logic [15:0] DIV_38K4 = 16'(CLK_HZ / `SNCS_RATE_38K4);
    localparam logic [15:0] DIV_115K2 = 16'(CLK_HZ / `SNCS_RATE_115K2);

    logic [7:0] sw_sync;
    logic [3:0] settle;
    logic [5:0] nv_addr;
    logic [1:0] nv_rate;
    logic [5:0] sw_addr;
    logic [1:0] sw_rate;
    logic [1:0] next_rate;
    logic [5:0] next_addr;
    sncs_pkg::sncs_state_t state;

    sncs_sync3 #(.WIDTH(8)) u_sync
    (
        .clock(clock),
        .srst(srst),
        .din(switch_on),
        .dout(sw_sync)
    );

    // Closed switch reads as one, switch one is the address LSB
    assign sw_addr = sw_sync[`SNCS_ADDR_MSB:`SNCS_ADDR_LSB];
    assign sw_rate = sw_sync[`SNCS_RATE_MSB:`SNCS_RATE_LSB];

    always_comb
    begin
        next_addr = (sw_addr == 6'h0) ? nv_addr : sw_addr;
        next_rate = (sw_rate == 2'h0) ? nv_rate : sw_rate;
    end

    // Sync pipe must flush after reset before the switches are trusted
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state <= sncs_pkg::SNCS_SETTLING;
            settle <= 4'h0;
        end
        else
        begin
            unique case (state)
                sncs_pkg::SNCS_SETTLING:
                begin
                    settle <= settle + 4'h1;
                    if (settle == `SNCS_SETTLE)
                        state <= sncs_pkg::SNCS_LATCH;
                end
                sncs_pkg::SNCS_LATCH:
                    state <= sncs_pkg::SNCS_RUN;
                sncs_pkg::SNCS_RUN:
                    state <= sncs_pkg::SNCS_RUN;
                default:
                    state <= sncs_pkg::SNCS_SETTLING;
            endcase
        end
    end

    // Latched once; later switch movement cannot disturb a running link
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            node_addr <= 6'h0;
            rate_code <= 2'h0;
            cfg_valid <= 1'b0;
        end
        else if (state == sncs_pkg::SNCS_LATCH)
        begin
            node_addr <= next_addr;
            rate_code <= next_rate;
            cfg_valid <= 1'b1;
        end
    end

    // Code 0 only if stored value is also 0; treated as the slowest rate
    always_ff @(posedge clock)
    begin
        if (srst)
            rate_div <= DIV_9K6;
        else if (state == sncs_pkg::SNCS_LATCH)
        begin
            unique case (next_rate)
                2'h2: rate_div <= DIV_38K4;
                2'h3: rate_div <= DIV_115K2;
                default: rate_div <= DIV_9K6;
            endcase
        end
    end

    // Stored settings are written by firmware from non-volatile memory
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            nv_addr <= 6'h0;
            nv_rate <= 2'h0;
            rs232_div <= DIV_9K6;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `SNCS_REG_NV)
            begin
                nv_addr <= reg_wdata[5:0];
                nv_rate <= reg_wdata[9:8];
            end
            // Point-to-point port is set only here, never from switches
            if (reg_addr == `SNCS_REG_232)
                rs232_div <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            reg_rdata <= 32'h0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `SNCS_REG_STATUS: reg_rdata <= {15'h0, cfg_valid, sw_sync,
                    rate_code, node_addr};
                `SNCS_REG_NV: reg_rdata <= {22'h0, nv_rate, 2'h0, nv_addr};
                `SNCS_REG_DIV: reg_rdata <= {16'h0, rate_div};
                `SNCS_REG_232: reg_rdata <= {16'h0, rs232_div};
            endcase
        end
        else
            reg_rdata <= 32'h0;
    end

    // Once latched, only a new reset may move the link settings
    chk_addr_hold: assert property
        (@(posedge clock) disable iff (srst)
        cfg_valid && $past(cfg_valid) |-> $stable(node_addr)
            && $stable(rate_code))
        else $error("latched config changed");
    chk_div_hold: assert property
        (@(posedge clock) disable iff (srst)
        cfg_valid && $past(cfg_valid) |-> $stable(rate_div))
        else $error("latched divider changed");
    chk_valid_hold: assert property
        (@(posedge clock) disable iff (srst)
        $past(cfg_valid) |-> cfg_valid)
        else $error("valid dropped without reset");
    chk_latch_once: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH
            |=> state == sncs_pkg::SNCS_RUN && cfg_valid)
        else $error("latch repeated");

    // The latch must wait for the switch pipe to flush
    chk_settle_time: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH |-> settle == `SNCS_SETTLE + 4'h1)
        else $error("latch before sync pipe flushed");
    chk_valid_time: assert property
        (@(posedge clock)
        $fell(srst) |-> !cfg_valid [*6] ##1 cfg_valid)
        else $error("latch timing wrong");
    chk_reset_state: assert property
        (@(posedge clock)
        $fell(srst) |-> !cfg_valid && node_addr == 6'h0 && rate_code == 2'h0
            && rate_div == DIV_9K6 && rs232_div == DIV_9K6)
        else $error("reset values wrong");

    // Zero switch fields fall back to the stored values
    chk_addr_fallback: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH && sw_addr == 6'h0
            |=> node_addr == $past(nv_addr))
        else $error("zero address not replaced");
    chk_addr_switch: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH && sw_addr != 6'h0
            |=> node_addr == $past(sw_sync[5:0]))
        else $error("switch address wrong");
    chk_rate_fallback: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH && sw_rate == 2'h0
            |=> rate_code == $past(nv_rate))
        else $error("zero rate not replaced");
    chk_rate_switch: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH && sw_rate != 2'h0
            |=> rate_code == $past(sw_sync[7:6]))
        else $error("switch rate wrong");
    chk_code_zero: assert property
        (@(posedge clock) disable iff (srst)
        state == sncs_pkg::SNCS_LATCH && sw_rate == 2'h0 && nv_rate == 2'h0
            |=> rate_code == 2'h0 && rate_div == DIV_9K6)
        else $error("unset rate not slowest");
    chk_rate_div: assert property
        (@(posedge clock) disable iff (srst)
        cfg_valid |-> rate_div == (rate_code == 2'h3 ? DIV_115K2 :
            rate_code == 2'h2 ? DIV_38K4 : DIV_9K6))
        else $error("divider mismatch");

    // Point-to-point divider belongs to software alone
    chk_rs232_free: assert property
        (@(posedge clock) disable iff (srst)
        !$past(reg_wr) |-> $stable(rs232_div))
        else $error("rs232 moved without write");
    chk_rs232_write: assert property
        (@(posedge clock) disable iff (srst)
        $changed(rs232_div) |-> $past(reg_wr)
            && $past(reg_addr) == `SNCS_REG_232)
        else $error("rs232 moved by other source");
endmodule // sncs_config_select

//--- dv/sncs_switch_bank.sv
`timescale 1ns/1ps
module sncs_switch_bank
(
    input wire logic clock,
    input wire logic [7:0] position,
    output logic [7:0] switch_on
);
    logic [7:0] last = 8'h00;
    int bounce = 0;
    int seed = 2;
    // Contacts chatter for a few cycles after a move, so settling matters
    always @(posedge clock)
    begin
        if (position !== last)
        begin
            last <= position;
            bounce <= 2;
            switch_on <= position ^ 8'($random(seed));
        end
        else if (bounce > 0)
        begin
            bounce <= bounce - 1;
            switch_on <= position ^ 8'($random(seed));
        end
        else
            switch_on <= last;
    end
endmodule // sncs_switch_bank

//--- dv/serial_node_config_select_tb.sv
`timescale 1ns/1ps
`include "sncs_defines.svh"
module serial_node_config_select_tb;
    logic clock, srst, reg_wr, reg_rd, cfg_valid;
    logic [7:0] switch_on, position, sw;
    logic [1:0] reg_addr, rate_code;
    logic [31:0] reg_wdata, reg_rdata, rd, stat;
    logic [5:0] node_addr;
    logic [15:0] rate_div, rs232_div, r232;
    logic [9:0] nv;
    logic [7:0] tsw [4] = '{8'h00, 8'h00, 8'h41, 8'hBF};
    logic [9:0] tnv [4] = '{10'h000, 10'h32A, 10'h215, 10'h100};
    int fails = 0, checked = 0, seed = 2, cyc = 0, rel, n, ea, er;
    sncs_config_select uut (.clock(clock), .srst(srst),
        .switch_on(switch_on), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .node_addr(node_addr), .rate_code(rate_code), .rate_div(rate_div),
        .cfg_valid(cfg_valid), .rs232_div(rs232_div));
    sncs_switch_bank bank (.clock(clock), .position(position),
        .switch_on(switch_on));
    initial
    begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) cyc <= cyc + 1;
    task summarize;
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask
    task wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rdt(input logic [1:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    function int div_of(int r);
        return `SNCS_CLK_HZ / (r == 2 ? `SNCS_RATE_38K4 :
            r == 3 ? `SNCS_RATE_115K2 : `SNCS_RATE_9K6);
    endfunction
    task outs;
        chk("node_addr", 32'(ea), {26'h0, node_addr});
        chk("rate_code", 32'(er), {30'h0, rate_code});
        chk("rate_div", 32'(div_of(er)), {16'h0, rate_div});
        rdt(2'h0);
        chk("status", stat, rd);
        rdt(2'h2);
        chk("div_reg", 32'(div_of(er)), rd);
    endtask
    initial
    begin
        srst = 1;
        reg_wr = 0;
        reg_rd = 0;
        reg_addr = 0;
        reg_wdata = 0;
        position = 0;
        for (int i = 0; i < 12; i++)
        begin
            sw = i < 4 ? tsw[i] : 8'($random(seed));
            nv = i < 4 ? tnv[i] : 10'($random(seed)) & 10'h33F;
            r232 = 16'($random(seed));
            ea = sw[5:0] != 0 ? sw[5:0] : nv[5:0];
            er = sw[7:6] != 0 ? sw[7:6] : nv[9:8];
            stat = {15'h0, 1'b1, sw, 2'(er), 6'(ea)};
            @(posedge clock);
            srst <= 1'b1;
            position <= sw;
            repeat (8) @(posedge clock);
            srst <= 1'b0;
            #1 rel = cyc;
            chk("rs232_div", 32'h1046, {16'h0, rs232_div});
            wr(2'h1, {22'h0, nv});
            n = 0;
            while (cfg_valid !== 1'b1 && n < 20)
            begin
                @(posedge clock);
                #1 n++;
            end
            if (n == 20)
            begin
                fails++;
                summarize;
            end
            chk("valid_edge", 32'h6, 32'(cyc - rel));
            outs;
            rdt(2'h1);
            chk("nv_reg", {22'h0, nv}, rd & 32'h33F);
            wr(2'h0, 32'hFFFF_FFFF);
            wr(2'h2, 32'hFFFF_FFFF);
            wr(2'h1, {22'h0, ~nv});
            wr(2'h3, {16'h0, r232});
            position <= ~sw;
            stat[15:8] = ~sw;
            repeat (8) @(posedge clock);
            #1 chk("rs232_div", {16'h0, r232}, {16'h0, rs232_div});
            outs;
        end
        summarize;
    end
endmodule // serial_node_config_select_tb
